// File: rtl/mrs_master_rx_status.v
`timescale 1ns/1ns
`include "mrs_map.vh"
// Operation
// RULE1: The host prepares a master reception by writing a slave-to-master control code (0,3,4,5,6,7) to the master control register.
// RULE2: The host then starts master communication with command code 1000 or 1001.
// RULE3: The device reports 0100 once arbitration is won and the frame is sent through the data-length field.
// RULE4: After the control field the receive buffer is made ready for incoming bytes; the code sets buf_ready_o only once the three headers are stored.
// RULE5: After the data-length field the slave address, control bits and length go into the receive buffer.
// RULE6: A byte that cannot be stored because the buffer is full yields code 0101.
// RULE7: If the host reads nothing within the mode deadline while full, the pending byte is refused with a NAK.
// RULE8: Receiving all bytes given by the data-length field yields code 0110.
// RULE9: After an end or abort the received bytes stay readable and their count is shown.
// RULE10: Lost arbitration during a master reception yields code 0111.
// RULE11: A slave NAK after the address or control field of a non-broadcast frame yields code 0111.
// RULE12: A device NAK after the data-length field of a non-broadcast frame yields code 0111.
// RULE13: A frame that ends before the full data length is received yields code 0111.
// RULE14: Every end or abort clears the master request flag; the code keeps it set when a start command arrives on the same edge.
// RULE15: The master code shares a read-only return-code register with an independent slave code.
// RULE16: Each change of the return-code register raises an interrupt request if selected.
// RULE17: The mode-1 full-buffer read deadline is taken from the timing table.
module mrs_master_rx_status #(
  parameter DEPTH_LOG2 = 6,
  parameter WAIT_M0    = `MRS_FULL_WAIT_M0_US * `MRS_CLK_MHZ,
  parameter WAIT_M1    = `MRS_FULL_WAIT_M1_US * `MRS_CLK_MHZ
) (
  input  wire       clk_sys_i,
  input  wire       nrst_i,
  input  wire [3:0] master_control_i,
  input  wire       cmd_write_i,
  input  wire [3:0] command_code_i,
  input  wire       irq_enable_i,
  input  wire       mode1_i,
  input  wire [3:0] slave_return_code_i,
  input  wire       arb_won_i,
  input  wire       arb_lost_i,
  input  wire       ctrl_done_i,
  input  wire       len_done_i,
  input  wire [7:0] slave_addr_i,
  input  wire [7:0] len_i,
  input  wire       broadcast_i,
  input  wire       slave_nak_i,
  input  wire       byte_valid_i,
  input  wire [7:0] byte_i,
  input  wire       frame_end_i,
  input  wire       buf_read_i,
  output reg  [7:0] return_code_register_o,
  output reg        master_request_flag_o,
  output reg  [7:0] receive_count_register_o,
  output reg  [7:0] rx_data_o,
  output wire       rx_empty_o,
  output wire       buf_ready_o,
  output wire       byte_ack_o,
  output reg        nak_o,
  output reg        irq_o
);

localparam DEPTH  = 1 << DEPTH_LOG2;
localparam S_IDLE = 2'b00;
localparam S_HDR  = 2'b01;
localparam S_DATA = 2'b10;

reg  [1:0]            state;
reg  [7:0]            mem [0:DEPTH-1];
reg  [DEPTH_LOG2:0]   wr_ptr;
reg  [DEPTH_LOG2:0]   rd_ptr;
reg  [1:0]            hdr_idx;
reg  [7:0]            hdr_ctrl;
reg  [7:0]            expect_len;
reg  [17:0]           wait_cnt;
reg                   full_seen;
reg  [3:0]            next_code;
reg                   fin;
wire                  full;
wire [17:0]           wait_lim;
reg  [7:0]            hdr_byte;
wire [7:0]            next_rcr;
wire                  push_hdr;

////////////////////////////////////////////////////////////////////////////////

assign full       = (wr_ptr - rd_ptr) == DEPTH[DEPTH_LOG2:0];
assign rx_empty_o = (wr_ptr == rd_ptr);
assign buf_ready_o = (state == S_DATA); // RULE4
// The mode 0 deadline at the system clock needs 18 bits; a narrower counter would cut it short.
assign wait_lim   = mode1_i ? WAIT_M1[17:0] : WAIT_M0[17:0]; // RULE7 RULE17
assign push_hdr   = (state == S_HDR) && !full;
assign next_rcr   = {next_code, slave_return_code_i}; // RULE15

////////////////////////////////////////////////////////////////////////////////

// Header bytes go out in a fixed order: slave address, control bits, then length.
always @* begin
  case (hdr_idx)
    2'd0: begin
      hdr_byte = slave_addr_i;
    end
    2'd1: begin
      hdr_byte = hdr_ctrl;
    end
    default: begin
      hdr_byte = expect_len;
    end
  endcase
end
assign byte_ack_o = (state == S_DATA) && byte_valid_i && !full;

// A master reception is only armed by a master command with a read control code.
wire ctrl_is_rx = (master_control_i == 4'h0) || (master_control_i == 4'h3) ||
                  (master_control_i[3:2] == 2'b01); // RULE1
wire start_cmd  = cmd_write_i && ctrl_is_rx &&
                  ((command_code_i == `MRS_CMD_MASTER_A) || (command_code_i == `MRS_CMD_MASTER_B)); // RULE2
wire all_rx     = receive_count_register_o == expect_len;

////////////////////////////////////////////////////////////////////////////////

// Priority of frame events: a lost arbitration beats a slave refusal, which beats the end of
// the frame; a start code is only reported from idle. Only one code can be posted per edge,
// so simultaneous events collapse onto the one that ends the reception.
// The full code is posted once per stall; a refusal after an expired deadline is folded
// into the abort at the end of the frame rather than posted on its own.

always @* begin
  next_code = return_code_register_o[`MRS_RCR_MASTER_RETURN_CODE_HI:`MRS_RCR_MASTER_RETURN_CODE_LO];
  fin       = 1'b0;
  if (master_request_flag_o) begin
    if (arb_lost_i) begin
      next_code = `MRS_MASTER_RETURN_CODE_ABORT; // RULE10
      fin       = 1'b1;
    end else if (slave_nak_i && !broadcast_i && state == S_IDLE) begin
      next_code = `MRS_MASTER_RETURN_CODE_ABORT; // RULE11
      fin       = 1'b1;
    end else if (frame_end_i) begin
      next_code = (state == S_DATA && all_rx && !nak_o) ? `MRS_MASTER_RETURN_CODE_DONE : `MRS_MASTER_RETURN_CODE_ABORT; // RULE8 RULE12 RULE13
      fin       = 1'b1;
    end else if (len_done_i && arb_won_i && state == S_IDLE) begin
      next_code = `MRS_MASTER_RETURN_CODE_START; // RULE3
    end else if (state == S_DATA && byte_valid_i && full && !full_seen) begin
      next_code = `MRS_MASTER_RETURN_CODE_FULL; // RULE6
    end
  end
end

////////////////////////////////////////////////////////////////////////////////

// The pointers carry one extra bit so that a full buffer and an empty one differ.
// Header bytes are not pushed while the buffer is full; they wait in place instead.
always @(posedge clk_sys_i or negedge nrst_i) begin
  if (!nrst_i) begin
    state                    <= S_IDLE;
    wr_ptr                   <= {(DEPTH_LOG2+1){1'b0}};
    rd_ptr                   <= {(DEPTH_LOG2+1){1'b0}};
    hdr_idx                  <= 2'd0;
    hdr_ctrl                 <= 8'h00;
    expect_len               <= 8'h00;
    wait_cnt                 <= 18'd0;
    full_seen                <= 1'b0;
    nak_o                    <= 1'b0;
    irq_o                    <= 1'b0;
    rx_data_o                <= 8'h00;
    master_request_flag_o    <= 1'b0;
    receive_count_register_o <= 8'h00;
    return_code_register_o   <= `MRS_RCR_RESET;
  end else begin
    return_code_register_o <= next_rcr; // RULE15
    // The request rises on the same edge as the new code, so the host never reads a stale value.
    irq_o                  <= irq_enable_i && (next_rcr != return_code_register_o); // RULE16
    if (start_cmd) begin
      master_request_flag_o    <= 1'b1;
      receive_count_register_o <= 8'h00;
      nak_o                    <= 1'b0;
      full_seen                <= 1'b0;
    end else if (fin) begin
      master_request_flag_o <= 1'b0; // RULE14
    end
    if (buf_read_i && !rx_empty_o) begin
      rx_data_o <= mem[rd_ptr[DEPTH_LOG2-1:0]]; // RULE9
      rd_ptr    <= rd_ptr + 1'b1;
    end
    if (ctrl_done_i)
      hdr_ctrl <= {4'h0, master_control_i};
    if (fin) begin
      state <= S_IDLE;
    end else begin
      case (state)
        S_IDLE: begin
          if (master_request_flag_o && len_done_i && arb_won_i) begin
            state      <= S_HDR;
            hdr_idx    <= 2'd0;
            expect_len <= len_i;
          end
        end
        S_HDR: begin
          if (push_hdr) begin
            mem[wr_ptr[DEPTH_LOG2-1:0]] <= hdr_byte; // RULE5
            wr_ptr  <= wr_ptr + 1'b1;
            hdr_idx <= hdr_idx + 2'd1;
            if (hdr_idx == 2'd2)
              state <= S_DATA;
          end
        end
        S_DATA: begin
          if (byte_ack_o) begin
            mem[wr_ptr[DEPTH_LOG2-1:0]] <= byte_i;
            wr_ptr                      <= wr_ptr + 1'b1;
            receive_count_register_o    <= receive_count_register_o + 8'd1; // RULE9
            full_seen                   <= 1'b0;
            wait_cnt                    <= 18'd0;
          end else if (byte_valid_i && full) begin
            full_seen <= 1'b1;
            // Deadline runs while the byte waits; expiry refuses it with a NAK.
            if (wait_cnt >= wait_lim)
              nak_o <= 1'b1; // RULE7
            else
              wait_cnt <= wait_cnt + 18'd1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
end

endmodule

// File: rtl/mrs_map.vh
`ifndef MRS_MAP_VH
`define MRS_MAP_VH
// Master return codes for master reception.
`define MRS_MASTER_RETURN_CODE_START      4'h4
`define MRS_MASTER_RETURN_CODE_FULL       4'h5
`define MRS_MASTER_RETURN_CODE_DONE       4'h6
`define MRS_MASTER_RETURN_CODE_ABORT      4'h7
`define MRS_RCR_RESET       8'hFF
// Return-code register field positions.
`define MRS_RCR_MASTER_RETURN_CODE_HI     7
`define MRS_RCR_MASTER_RETURN_CODE_LO     4
`define MRS_RCR_SLAVE_RETURN_CODE_HI     3
`define MRS_RCR_SLAVE_RETURN_CODE_LO     0
// Commands that request master communication.
`define MRS_CMD_MASTER_A    4'h8
`define MRS_CMD_MASTER_B    4'h9
// Host read deadline with a full buffer, in microseconds per mode.
`define MRS_FULL_WAIT_M0_US 1570
`define MRS_FULL_WAIT_M1_US 390
`define MRS_CLK_MHZ         100
`endif

// File: sim/mrs_master_rx_checker.sv
`timescale 1ns/1ns
module mrs_master_rx_checker (
  input wire       clk_sys_i, nrst_i, cmd_write_i, irq_enable_i, arb_won_i, arb_lost_i, len_done_i,
  input wire       byte_valid_i, frame_end_i, master_request_flag_o, byte_ack_o, nak_o, irq_o,
  input wire [3:0] master_control_i, command_code_i,
  input wire [7:0] return_code_register_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  wire [3:0] mc = return_code_register_o[7:4];
  wire       fl = master_request_flag_o;
  wire       go = cmd_write_i && command_code_i[3:1] == 3'h4 && master_control_i inside {0, 3, 4, 5, 6, 7};
  // Any command write masks frame checks, since a start in the same cycle wins over an abort.
  a_start_flag: assert property (go |=> fl) else $error("no request");
  a_start_code: assert property (fl && !cmd_write_i && len_done_i && arb_won_i |=> ##[0:1] mc == 4'h4)
    else $error("no start code");
  a_lost_abort: assert property (fl && !cmd_write_i && arb_lost_i |=> ##[0:1] (mc == 4'h7 && !fl))
    else $error("no abort");
  a_end_code: assert property (fl && !cmd_write_i && frame_end_i |=> ##[0:1] (mc[3:1] == 3'h3 && !fl))
    else $error("bad end");
  a_ack_valid: assert property (byte_ack_o |-> byte_valid_i) else $error("ack alone");
  a_irq_change: assert property ($changed(return_code_register_o) && $past(irq_enable_i) |-> irq_o)
    else $error("no irq");
  a_irq_cause: assert property (irq_o |-> $changed(return_code_register_o))
    else $error("stray irq");
  a_nak_hold: assert property (nak_o && !cmd_write_i |=> nak_o) else $error("nak dropped");
  a_flag_clear: assert property ($fell(fl) && $past(nrst_i) |-> ##[0:1] mc[3:1] == 3'h3)
    else $error("flag fell");
  cover property (mc == 4'h6);
  cover property (mc == 4'h5 ##[1:60] nak_o);
  cover property (fl && arb_lost_i);
endmodule
bind mrs_master_rx_status mrs_master_rx_checker u_mrs_master_rx_checker (.*);

// File: sim/mrs_remote_unit.sv
`timescale 1ns/1ns
module mrs_remote_unit (
  input  wire       clk_sys_i, byte_ack_o,
  output reg        arb_won_i = 1'b0, arb_lost_i = 1'b0, ctrl_done_i = 1'b0, len_done_i = 1'b0,
  output reg        broadcast_i = 1'b0, slave_nak_i = 1'b0, byte_valid_i = 1'b0, frame_end_i = 1'b0,
  output reg  [7:0] slave_addr_i = 8'h21, len_i = 8'h00, byte_i = 8'h00
);
  // Event bits are {frame_end, slave_nak, arb_lost, len_done, ctrl_done}, each seen at one edge.
  task ev(input [4:0] m);
    begin
      @(posedge clk_sys_i) #1;
      {frame_end_i, slave_nak_i, arb_lost_i, len_done_i, ctrl_done_i} = m;
      @(posedge clk_sys_i) #1;
      {frame_end_i, slave_nak_i, arb_lost_i, len_done_i, ctrl_done_i} = 5'h00;
      if (m[4]) arb_won_i = 1'b0;
    end
  endtask
  task hdr(input [7:0] n);
    begin
      arb_won_i = 1'b1;
      len_i = n;
      ev(5'h01);
      ev(5'h02);
      len_i = ~n;
    end
  endtask
  // A byte the controller never takes is given up after the bound, as a refused sender would.
  task send(input [7:0] b, output ok);
    integer i;
    begin
      @(posedge clk_sys_i) #1;
      byte_i = b;
      byte_valid_i = 1'b1;
      ok = 1'b0;
      for (i = 0; i < 60 && !ok; i = i + 1) begin
        @(posedge clk_sys_i);
        ok = byte_ack_o;
      end
      #1;
      byte_valid_i = 1'b0;
      byte_i = ~b;
    end
  endtask
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ns
module testbench;
  reg        clk_sys_i = 1'b0, nrst_i = 1'b0, cmd_write_i = 1'b0, irq_enable_i = 1'b1, mode1_i = 1'b0;
  reg        buf_read_i = 1'b0, ok;
  reg  [3:0] master_control_i = 4'h0, command_code_i = 4'h0, slave_return_code_i = 4'hA;
  integer    miscompares = 0, num_checks = 0;
  wire       arb_won_i, arb_lost_i, ctrl_done_i, len_done_i, broadcast_i, slave_nak_i, byte_valid_i, frame_end_i;
  wire       master_request_flag_o, rx_empty_o, buf_ready_o, byte_ack_o, nak_o, irq_o;
  wire [7:0] slave_addr_i, len_i, byte_i, return_code_register_o, receive_count_register_o, rx_data_o;
  // A four-entry buffer lets one data byte after the three headers fill it.
  mrs_master_rx_status #(.DEPTH_LOG2(2), .WAIT_M0(20), .WAIT_M1(10)) u_mrs_master_rx_status (.*);
  mrs_remote_unit u_mrs_remote_unit (.*);
  task chk(input [63:0] nm, input [7:0] seen, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task start(input [3:0] cc, input [3:0] ctl);
    begin
      @(posedge clk_sys_i) #1;
      master_control_i = ctl;
      command_code_i = cc;
      cmd_write_i = 1'b1;
      @(posedge clk_sys_i) #1;
      cmd_write_i = 1'b0;
      chk("flag", {7'h00, master_request_flag_o}, 8'h01);
    end
  endtask
  task code(input [3:0] c);
    begin
      @(posedge clk_sys_i) #1;
      chk("rcr", return_code_register_o, {c, 4'hA});
    end
  endtask
  task rd(input [7:0] exp);
    begin
      @(posedge clk_sys_i) #1;
      buf_read_i = 1'b1;
      @(posedge clk_sys_i) #1;
      buf_read_i = 1'b0;
      chk("rx_data", rx_data_o, exp);
    end
  endtask
  task t_normal;
    begin
      start(4'h8, 4'h3);
      u_mrs_remote_unit.hdr(8'h01);
      code(4'h4);
      u_mrs_remote_unit.send(8'h5C, ok);
      chk("ack", {7'h00, ok}, 8'h01);
      chk("ready", {7'h00, buf_ready_o}, 8'h01);
      u_mrs_remote_unit.ev(5'h10);
      code(4'h6);
      chk("ready", {7'h00, buf_ready_o}, 8'h00);
      chk("flag", {7'h00, master_request_flag_o}, 8'h00);
      chk("count", receive_count_register_o, 8'h01);
      rd(8'h21);
      rd(8'h03);
      rd(8'h01);
      rd(8'h5C);
      chk("empty", {7'h00, rx_empty_o}, 8'h01);
    end
  endtask
  task t_full;
    begin
      start(4'h9, 4'h7);
      mode1_i = 1'b1;
      u_mrs_remote_unit.hdr(8'h02);
      u_mrs_remote_unit.send(8'h11, ok);
      u_mrs_remote_unit.send(8'h22, ok);
      chk("ack", {7'h00, ok}, 8'h00);
      chk("rcr", return_code_register_o, 8'h5A);
      chk("nak", {7'h00, nak_o}, 8'h01);
      u_mrs_remote_unit.ev(5'h10);
      code(4'h7);
      chk("count", receive_count_register_o, 8'h01);
      rd(8'h21);
      rd(8'h07);
      rd(8'h02);
      rd(8'h11);
    end
  endtask
  task t_abort(input [4:0] m);
    begin
      start(4'h8, 4'h0);
      u_mrs_remote_unit.arb_won_i = m[3];
      u_mrs_remote_unit.ev(m);
      code(4'h7);
      chk("flag", {7'h00, master_request_flag_o}, 8'h00);
    end
  endtask
  task t_bcast;
    begin
      start(4'h8, 4'h4);
      irq_enable_i = 1'b0;
      u_mrs_remote_unit.broadcast_i = 1'b1;
      u_mrs_remote_unit.ev(5'h08);
      chk("flag", {7'h00, master_request_flag_o}, 8'h01);
      u_mrs_remote_unit.ev(5'h04);
      code(4'h7);
      chk("flag", {7'h00, master_request_flag_o}, 8'h00);
      u_mrs_remote_unit.broadcast_i = 1'b0;
      irq_enable_i = 1'b1;
    end
  endtask
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    #1;
    nrst_i = 1'b1;
    chk("rcr", return_code_register_o, 8'hFF);
    t_normal;
    t_full;
    t_abort(5'h04);
    t_abort(5'h08);
    t_bcast;
    stop_test;
  end
endmodule
